//--- design/dac_frame_pkg.sv
// Shared constants for the serial command frame link
`default_nettype none
package dac_frame_pkg;
  localparam int NUM_CH = 4;
  localparam int FRAME_BITS = 24;
  localparam int CHECK_BITS = 8;
  localparam int FRAME_BITS_CHECK = FRAME_BITS + CHECK_BITS;
  localparam int CNT_W = 6;
  // Header field positions
  localparam int RW_BIT = 23;
  localparam int DEV_HI_BIT = 22;
  localparam int DEV_LO_BIT = 21;
  localparam int REG_MSB = 20;
  localparam int REG_LSB = 18;
  localparam int CH_MSB = 17;
  localparam int CH_LSB = 16;
  localparam int DATA_MSB = 15;
  // Register select codes
  localparam logic [2:0] REG_CODE = 3'h0;
  localparam logic [2:0] REG_GAIN = 3'h2;
  localparam logic [2:0] REG_GAIN_ALL = 3'h3;
  localparam logic [2:0] REG_OFFSET = 3'h4;
  localparam logic [2:0] REG_OFFSET_ALL = 3'h5;
  localparam logic [2:0] REG_CONTROL = 3'h7;
  // Control word layout
  localparam int CTRL_RANGE_LSB = 0;
  localparam int CTRL_INT_EN_BIT = 5;
  localparam int CTRL_BOOST_BIT = 6;
  localparam int CTRL_OUT_EN_BIT = 8;
  localparam int CTRL_SUB_LSB = 13;
  localparam int BOOST_W = 13;
  localparam logic [2:0] CTRL_SUB_CHANNEL = 3'h0;
  localparam logic [2:0] CTRL_SUB_BOOST = 3'h1;
  // Reset values and zero-point codes
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET = 16'hffff;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [15:0] ZERO_MID = 16'h8000;
  localparam logic [15:0] ZERO_LOW = 16'h0000;
  // Timing
  localparam int CLOCK_MHZ = 100;
  localparam int CAL_TIME_US = 200;
  localparam int CAL_CYCLES = CAL_TIME_US * CLOCK_MHZ;
  localparam int WAIT_W = 16;
  localparam int SCLK_HALF_CYCLES = 4;
  localparam int RESET_HOLD_CYCLES = 8;
  // Host register offsets
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_COMMAND = 12'h004;
  localparam logic [11:0] ADDR_CODE = 12'h008;
  localparam logic [11:0] ADDR_BOOST = 12'h00c;
  localparam logic [11:0] ADDR_RAW = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  // Host config and command fields
  localparam int CFG_CH_LSB = 0;
  localparam int CFG_RANGE_LSB = 2;
  localparam int CFG_DEV_LSB = 5;
  localparam int CFG_CHECK_BIT = 7;
  localparam int CFG_SKIP_RESET_BIT = 8;
  localparam int CFG_ZERO_FIRST_BIT = 9;
  localparam int CFG_ZERO_MID_BIT = 10;
  localparam int CMD_BRINGUP_BIT = 0;
  localparam int CMD_RAW_BIT = 1;
endpackage
`default_nettype wire

//--- design/dac_link_if.sv
// Three-wire serial link plus reset line between host and converter
`timescale 1ns/100ps
`default_nettype none
interface dac_link_if;
  logic sclk;
  logic sync_n;
  logic sdin;
  logic dev_reset;
  modport host (output sclk, output sync_n, output sdin, output dev_reset);
  modport device (input sclk, input sync_n, input sdin, input dev_reset);
endinterface
`default_nettype wire

//--- design/dac_frame_device.sv
// Converter end: frame capture, decode and channel register file
`timescale 1ns/100ps
`default_nettype none
module dac_frame_device
  import dac_frame_pkg::*;
#(
  parameter int CAL_CYCLES_P = CAL_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Link
  dac_link_if.device link,
  // Strap and option pins
  input wire logic i_strap_address_pin_hi,
  input wire logic i_strap_address_pin_lo,
  input wire logic i_check_enable,
  // Channel registers
  output logic [NUM_CH-1:0][15:0] o_code,
  output logic [NUM_CH-1:0][15:0] o_gain,
  output logic [NUM_CH-1:0][15:0] o_offset,
  output logic [NUM_CH-1:0][2:0] o_range,
  output logic [NUM_CH-1:0] o_internal_enable,
  output logic [NUM_CH-1:0] o_boost_supply_enable,
  output logic [NUM_CH-1:0] o_output_drive_enable,
  output logic [BOOST_W-1:0] o_boost_config,
  // Calibration
  output logic [NUM_CH-1:0] o_cal_start,
  output logic [NUM_CH-1:0] o_cal_busy,
  // Frame status
  output logic o_frame_done,
  output logic o_frame_error
);
  logic [2:0] sclk_s;
  logic [2:0] sync_s;
  logic [1:0] sdin_s;
  logic [1:0] rst_s;
  logic [1:0] hi_s;
  logic [1:0] lo_s;
  logic [1:0] chk_s;
  logic [31:0] shift;
  logic [CNT_W-1:0] bit_cnt;
  logic [NUM_CH-1:0][WAIT_W-1:0] cal_cnt;

  // Pin synchronisers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sclk_s <= 3'h7;
      sync_s <= 3'h7;
      sdin_s <= 2'h0;
      rst_s <= 2'h0;
      hi_s <= 2'h0;
      lo_s <= 2'h0;
      chk_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      sync_s <= {sync_s[1:0], link.sync_n};
      sdin_s <= {sdin_s[0], link.sdin};
      rst_s <= {rst_s[0], link.dev_reset};
      hi_s <= {hi_s[0], i_strap_address_pin_hi};
      lo_s <= {lo_s[0], i_strap_address_pin_lo};
      chk_s <= {chk_s[0], i_check_enable};
    end
  end

  wire dev_rst = i_rst | rst_s[1];
  wire in_frame = ~sync_s[1];
  wire sclk_fall = sclk_s[2] & ~sclk_s[1];
  wire sync_rise = ~sync_s[2] & sync_s[1];
  wire check_on = chk_s[1];
  wire [CNT_W-1:0] expected = check_on ? CNT_W'(FRAME_BITS_CHECK) : CNT_W'(FRAME_BITS);
  wire [23:0] header = check_on ? shift[31:8] : shift[23:0];
  wire length_ok = (bit_cnt == expected);
  wire addr_ok = (header[DEV_HI_BIT] == hi_s[1]) & (header[DEV_LO_BIT] == lo_s[1]);
  wire is_write = ~header[RW_BIT];
  wire frame_ok = sync_rise & length_ok & addr_ok & is_write;
  wire [2:0] reg_sel = header[REG_MSB:REG_LSB];
  wire [1:0] ch_sel = header[CH_MSB:CH_LSB];
  wire [15:0] data = header[DATA_MSB:0];
  wire [2:0] sub_sel = data[CTRL_SUB_LSB+2:CTRL_SUB_LSB];
  wire wr_code = frame_ok & (reg_sel == REG_CODE);
  wire wr_gain = frame_ok & (reg_sel == REG_GAIN);
  wire wr_gain_all = frame_ok & (reg_sel == REG_GAIN_ALL);
  wire wr_offset = frame_ok & (reg_sel == REG_OFFSET);
  wire wr_offset_all = frame_ok & (reg_sel == REG_OFFSET_ALL);
  wire wr_control = frame_ok & (reg_sel == REG_CONTROL);
  wire wr_chan_ctrl = wr_control & (sub_sel == CTRL_SUB_CHANNEL);
  wire wr_boost = wr_control & (sub_sel == CTRL_SUB_BOOST);

  // Bit capture on falling serial clock
  always_ff @(posedge i_clock) begin
    if (dev_rst) begin
      shift <= 32'h0;
      bit_cnt <= '0;
    end else if (!in_frame) begin
      bit_cnt <= '0;
    end else if (sclk_fall) begin
      shift <= {shift[30:0], sdin_s[1]};
      if (bit_cnt != '1) begin
        bit_cnt <= bit_cnt + CNT_W'(1);
      end
    end
  end

  // Frame status
  always_ff @(posedge i_clock) begin
    if (dev_rst) begin
      o_frame_done <= 1'b0;
      o_frame_error <= 1'b0;
    end else begin
      o_frame_done <= frame_ok;
      o_frame_error <= sync_rise & ~length_ok;
    end
  end

  // Boost supply settings
  always_ff @(posedge i_clock) begin
    if (dev_rst) begin
      o_boost_config <= '0;
    end else if (wr_boost) begin
      o_boost_config <= data[BOOST_W-1:0];
    end
  end

  // Per-channel register file and calibration timer
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    wire sel = (ch_sel == 2'(i));
    always_ff @(posedge i_clock) begin
      if (dev_rst) begin
        o_code[i] <= CODE_RESET;
        o_gain[i] <= GAIN_RESET;
        o_offset[i] <= OFFSET_RESET;
        o_range[i] <= 3'h0;
        o_internal_enable[i] <= 1'b0;
        o_boost_supply_enable[i] <= 1'b0;
        o_output_drive_enable[i] <= 1'b0;
      end else begin
        if (wr_code & sel) begin
          o_code[i] <= data;
        end
        if ((wr_gain & sel) | wr_gain_all) begin
          o_gain[i] <= data;
        end
        if ((wr_offset & sel) | wr_offset_all) begin
          o_offset[i] <= data;
        end
        if (wr_chan_ctrl & sel) begin
          o_range[i] <= data[CTRL_RANGE_LSB+2:CTRL_RANGE_LSB];
          o_internal_enable[i] <= data[CTRL_INT_EN_BIT];
          o_boost_supply_enable[i] <= data[CTRL_BOOST_BIT];
          o_output_drive_enable[i] <= data[CTRL_OUT_EN_BIT];
        end
      end
    end
    always_ff @(posedge i_clock) begin
      if (dev_rst) begin
        o_cal_start[i] <= 1'b0;
        o_cal_busy[i] <= 1'b0;
        cal_cnt[i] <= '0;
      end else begin
        o_cal_start[i] <= wr_code & sel;
        if (wr_code & sel) begin
          cal_cnt[i] <= WAIT_W'(CAL_CYCLES_P);
          o_cal_busy[i] <= 1'b1;
        end else if (cal_cnt[i] != '0) begin
          cal_cnt[i] <= cal_cnt[i] - WAIT_W'(1);
          if (cal_cnt[i] == WAIT_W'(1)) begin
            o_cal_busy[i] <= 1'b0;
          end
        end
      end
    end
  end
endmodule // dac_frame_device
`default_nettype wire

//--- design/dac_frame_host.sv
// Host end: APB registers, bring-up sequencer and serial frame sender
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Host resets device before any configuration
// - Host writes boost settings after reset
// - Host writes channel control, drive off
// - Code write starts channel calibration
// - Host waits 200 us before drive on
// - Host rewrites control with drive enabled
// - Range change repeats sequence without reset
// - Host drives zero point before disabling
// - Frame is 24 bits, 32 with check
// - Header is rw, device, register, channel
// - Act only when device bits match straps
// - Decode code, gain, gain all, offset
// - Code write takes low sixteen bits
// - Irrelevant header bits are ignored
// - Select 101 writes all offset registers
// - Select 010 writes one gain register
module dac_frame_host
  import dac_frame_pkg::*;
#(
  parameter int CAL_WAIT_P = CAL_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Link
  dac_link_if.host link
);
  typedef enum {S_IDLE, S_RESET, S_BOOST, S_ZERO, S_CTRL_OFF, S_CODE, S_WAIT,
                S_CTRL_ON, S_RAW} seq_e;
  typedef enum {T_IDLE, T_SHIFT, T_TAIL} tx_e;
  seq_e state;
  tx_e tx_state;
  logic [10:0] cfg;
  logic [15:0] code;
  logic [BOOST_W-1:0] boost;
  logic [23:0] raw;
  logic [WAIT_W-1:0] wait_cnt;
  logic sent;
  logic tx_go;
  logic [31:0] tx_word;
  logic [CNT_W-1:0] tx_bits;
  logic [7:0] div;
  logic sclk;
  logic sync_n;
  logic sdin;
  logic dev_reset;

  // APB decode
  wire access = i_psel & i_penable;
  wire wr_en = access & o_pready & i_pwrite;
  wire hit = (i_paddr == ADDR_CONFIG) | (i_paddr == ADDR_COMMAND) | (i_paddr == ADDR_CODE)
             | (i_paddr == ADDR_BOOST) | (i_paddr == ADDR_RAW) | (i_paddr == ADDR_STATUS);
  wire busy = (state != S_IDLE);
  wire cmd_wr = wr_en & (i_paddr == ADDR_COMMAND) & ~busy;
  wire [31:0] rd_mux = (i_paddr == ADDR_CONFIG) ? {21'h0, cfg} :
                       (i_paddr == ADDR_CODE) ? {16'h0, code} :
                       (i_paddr == ADDR_BOOST) ? {19'h0, boost} :
                       (i_paddr == ADDR_RAW) ? {8'h0, raw} :
                       (i_paddr == ADDR_STATUS) ? {28'h0, 3'(state), busy} : 32'h0;

  // Config fields
  wire [1:0] ch = cfg[CFG_CH_LSB+1:CFG_CH_LSB];
  wire [2:0] range = cfg[CFG_RANGE_LSB+2:CFG_RANGE_LSB];
  wire [1:0] dev = cfg[CFG_DEV_LSB+1:CFG_DEV_LSB];
  wire check_on = cfg[CFG_CHECK_BIT];
  wire [15:0] zero_code = cfg[CFG_ZERO_MID_BIT] ? ZERO_MID : ZERO_LOW;
  wire [15:0] ctrl_word = 16'((1 << CTRL_INT_EN_BIT) | (1 << CTRL_BOOST_BIT)
                          | (int'(range) << CTRL_RANGE_LSB));
  wire [15:0] ctrl_on = ctrl_word | 16'(1 << CTRL_OUT_EN_BIT);
  wire [15:0] boost_word = {CTRL_SUB_BOOST, boost};

  // Frame content per sequencer state
  wire [2:0] f_reg = (state == S_ZERO || state == S_CODE) ? REG_CODE : REG_CONTROL;
  wire [15:0] f_data = (state == S_BOOST) ? boost_word :
                       (state == S_ZERO) ? zero_code :
                       (state == S_CODE) ? code :
                       (state == S_CTRL_ON) ? ctrl_on : ctrl_word;
  wire [23:0] f_frame = (state == S_RAW) ? raw : {1'b0, dev, f_reg, ch, f_data};
  wire tx_idle = (tx_state == T_IDLE) & ~tx_go;

  // APB slave registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
      cfg <= '0;
      code <= 16'h0;
      boost <= '0;
      raw <= 24'h0;
    end else begin
      o_pready <= access & ~o_pready;
      o_pslverr <= access & ~o_pready & ~hit;
      o_prdata <= (access & ~o_pready & ~i_pwrite) ? rd_mux : 32'h0;
      if (wr_en & (i_paddr == ADDR_CONFIG) & ~busy) begin
        cfg <= i_pwdata[10:0];
      end
      if (wr_en & (i_paddr == ADDR_CODE) & ~busy) begin
        code <= i_pwdata[15:0];
      end
      if (wr_en & (i_paddr == ADDR_BOOST) & ~busy) begin
        boost <= i_pwdata[BOOST_W-1:0];
      end
      if (wr_en & (i_paddr == ADDR_RAW) & ~busy) begin
        raw <= i_pwdata[23:0];
      end
    end
  end

  // Bring-up sequencer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= S_IDLE;
      sent <= 1'b0;
      tx_go <= 1'b0;
      tx_word <= 32'h0;
      wait_cnt <= '0;
      dev_reset <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (cmd_wr & i_pwdata[CMD_BRINGUP_BIT]) begin
            if (!cfg[CFG_SKIP_RESET_BIT]) begin
              state <= S_RESET;
              dev_reset <= 1'b1;
              wait_cnt <= WAIT_W'(RESET_HOLD_CYCLES);
            end else if (cfg[CFG_ZERO_FIRST_BIT]) begin
              state <= S_ZERO;
            end else begin
              state <= S_CTRL_OFF;
            end
          end else if (cmd_wr & i_pwdata[CMD_RAW_BIT]) begin
            state <= S_RAW;
          end
        end
        S_RESET: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - WAIT_W'(1);
          end else if (dev_reset) begin
            dev_reset <= 1'b0;
            wait_cnt <= WAIT_W'(RESET_HOLD_CYCLES);
          end else begin
            state <= S_BOOST;
          end
        end
        S_WAIT: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - WAIT_W'(1);
          end else begin
            state <= S_CTRL_ON;
          end
        end
        default: begin
          if (tx_idle & ~sent) begin
            tx_go <= 1'b1;
            tx_word <= {f_frame, 8'h00};
            sent <= 1'b1;
          end else if (tx_idle & sent) begin
            sent <= 1'b0;
            unique case (state)
              S_BOOST: state <= S_CTRL_OFF;
              S_ZERO: state <= S_CTRL_OFF;
              S_CTRL_OFF: state <= S_CODE;
              S_CODE: begin
                state <= S_WAIT;
                wait_cnt <= WAIT_W'(CAL_WAIT_P);
              end
              default: state <= S_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // Serial frame sender, data changes on rising edge, MSB first
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_state <= T_IDLE;
      sclk <= 1'b1;
      sync_n <= 1'b1;
      sdin <= 1'b0;
      div <= 8'h0;
      tx_bits <= '0;
    end else begin
      unique case (tx_state)
        T_IDLE: begin
          if (tx_go) begin
            tx_state <= T_SHIFT;
            sync_n <= 1'b0;
            sdin <= tx_word[31];
            div <= 8'h0;
            tx_bits <= CNT_W'(1);
          end
        end
        T_SHIFT: begin
          if (div == 8'(SCLK_HALF_CYCLES - 1)) begin
            div <= 8'h0;
            sclk <= ~sclk;
            if (!sclk) begin
              if (tx_bits == (check_on ? CNT_W'(FRAME_BITS_CHECK) : CNT_W'(FRAME_BITS))) begin
                tx_state <= T_TAIL;
              end else begin
                sdin <= tx_word[31 - int'(tx_bits)];
                tx_bits <= tx_bits + CNT_W'(1);
              end
            end
          end else begin
            div <= div + 8'h1;
          end
        end
        T_TAIL: begin
          if (div == 8'(SCLK_HALF_CYCLES - 1)) begin
            div <= 8'h0;
            sync_n <= 1'b1;
            tx_state <= T_IDLE;
          end else begin
            div <= div + 8'h1;
          end
        end
      endcase
    end
  end

  assign link.sclk = sclk;
  assign link.sync_n = sync_n;
  assign link.sdin = sdin;
  assign link.dev_reset = dev_reset;
endmodule // dac_frame_host
`default_nettype wire

//--- testbench/dac_frame_monitor.sv
// Link and converter-side checks for the host and converter pair
`timescale 1ns/100ps
`default_nettype none
module dac_frame_monitor
  import dac_frame_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Link
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic dev_reset,
  // Converter outputs
  input wire logic [NUM_CH-1:0] o_cal_start,
  input wire logic [NUM_CH-1:0] o_cal_busy,
  input wire logic [NUM_CH-1:0] o_output_drive_enable,
  input wire logic o_frame_done
);
  logic sclk_q;
  logic [CNT_W-1:0] bit_cnt;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Falling edges of the serial clock within a frame
  always_ff @(posedge i_clock) begin
    sclk_q <= sclk;
  end
  always_ff @(posedge i_clock) begin
    if (i_rst || sync_n) begin
      bit_cnt <= '0;
    end else if (sclk_q && !sclk) begin
      bit_cnt <= bit_cnt + CNT_W'(1);
    end
  end
  chk_idle_clock_high: assert property (sync_n |-> sclk)
    else $error("serial clock low outside a frame");
  chk_data_steady_fall: assert property ($fell(sclk) |-> $stable(sdin))
    else $error("data changed at the sampling edge");
  chk_frame_bit_count: assert property ($rose(sync_n) |->
    (bit_cnt == CNT_W'(FRAME_BITS)) || (bit_cnt == CNT_W'(FRAME_BITS_CHECK)))
    else $error("frame closed with a wrong bit count");
  chk_frame_gap_min: assert property ($rose(sync_n) |-> sync_n[*3])
    else $error("frame select gap too short");
  chk_reset_pulse_len: assert property ($rose(dev_reset) |->
    dev_reset[*8] ##1 dev_reset ##1 (!dev_reset && sync_n)[*8])
    else $error("reset pulse or recovery too short");
  chk_cal_on_code: assert property (o_cal_start[0] |-> ##[0:1] o_cal_busy[0])
    else $error("calibration did not start");
  chk_drive_after_cal: assert property ($rose(o_output_drive_enable[0]) |->
    !o_cal_busy[0])
    else $error("drive enabled during calibration");
  chk_drive_by_frame: assert property ($rose(o_output_drive_enable[0]) |->
    o_frame_done)
    else $error("drive enabled without a frame");
  chk_done_after_end: assert property (o_frame_done |-> $past(sync_n, 2))
    else $error("frame executed before select released");
endmodule // dac_frame_monitor
`default_nettype wire

//--- testbench/tb_dac_frame_decode_and_bringup.sv
// Self-checking bench for the host and converter frame link
`timescale 1ns/100ps
`default_nettype none
module tb_dac_frame_decode_and_bringup;
  import dac_frame_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] strap1 = 2'h1;
  logic [1:0] strap2 = 2'h2;
  logic chk1 = 1'b0;
  logic chk2 = 1'b0;
  logic [NUM_CH-1:0][15:0] code1, gain1, code2, gain2, off2;
  logic [NUM_CH-1:0][2:0] range1;
  logic [NUM_CH-1:0] int1, boost1, drive1, drive2, cal1, busy1, busy2;
  logic [BOOST_W-1:0] bcfg1;
  logic done1, done2, err2, er;
  logic [31:0] rd;
  logic [15:0] exp_code [NUM_CH];
  logic [15:0] exp_gain [NUM_CH];
  logic [15:0] exp_off [NUM_CH];
  logic [2:0] regs [5] = '{REG_CODE, REG_GAIN, REG_GAIN_ALL, REG_OFFSET, REG_OFFSET_ALL};
  int seed = 49;
  int failures = 0;
  int cmp_count = 0;
  int n_done = 0;
  int n_err = 0;
  dac_link_if link();
  dac_link_if link2();
  always #5 i_clock = ~i_clock;
  dac_frame_host #(.CAL_WAIT_P(300)) dac_frame_host_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link));
  dac_frame_device #(.CAL_CYCLES_P(300)) dac_frame_device_i (.i_clock(i_clock), .i_rst(i_rst),
    .link(link), .i_strap_address_pin_hi(strap1[1]), .i_strap_address_pin_lo(strap1[0]),
    .i_check_enable(chk1), .o_code(code1), .o_gain(gain1), .o_offset(), .o_range(range1),
    .o_internal_enable(int1),
    .o_boost_supply_enable(boost1), .o_output_drive_enable(drive1), .o_boost_config(bcfg1),
    .o_cal_start(cal1), .o_cal_busy(busy1), .o_frame_done(done1), .o_frame_error());
  dac_frame_device #(.CAL_CYCLES_P(50)) dac_frame_device_i2 (.i_clock(i_clock), .i_rst(i_rst),
    .link(link2), .i_strap_address_pin_hi(strap2[1]), .i_strap_address_pin_lo(strap2[0]),
    .i_check_enable(chk2), .o_code(code2), .o_gain(gain2), .o_offset(off2), .o_range(),
    .o_internal_enable(), .o_boost_supply_enable(),
    .o_output_drive_enable(drive2), .o_boost_config(), .o_cal_start(), .o_cal_busy(busy2),
    .o_frame_done(done2), .o_frame_error(err2));
  dac_frame_monitor dac_frame_monitor_i (.i_clock(i_clock), .i_rst(i_rst), .sclk(link.sclk),
    .sync_n(link.sync_n), .sdin(link.sdin), .dev_reset(link.dev_reset), .o_cal_start(cal1),
    .o_cal_busy(busy1), .o_output_drive_enable(drive1), .o_frame_done(done1));
  always @(posedge i_clock) begin
    n_done = n_done + int'(done2 === 1'b1);
    n_err = n_err + int'(err2 === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1) begin
      @(posedge i_clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    rd = 32'h1;
    repeat (2) @(posedge i_clock);
    while (rd[0] !== 1'b0 && n < 1000) begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end
    chk(32'(rd[0]), 32'h0);
  endtask
  function automatic void model(input logic [2:0] r, input logic [1:0] c, input logic [15:0] d);
    for (int k = 0; k < NUM_CH; k++) begin
      exp_code[k] = (r == REG_CODE && c == 2'(k)) ? d : exp_code[k];
      exp_gain[k] = (r == REG_GAIN_ALL || (r == REG_GAIN && c == 2'(k))) ? d : exp_gain[k];
      exp_off[k] = (r == REG_OFFSET_ALL || (r == REG_OFFSET && c == 2'(k))) ? d : exp_off[k];
    end
  endfunction
  task automatic cmp2();
    for (int k = 0; k < NUM_CH; k++) begin
      chk(32'(code2[k]), 32'(exp_code[k]));
      chk(32'(gain2[k]), 32'(exp_gain[k]));
      chk(32'(off2[k]), 32'(exp_off[k]));
    end
  endtask
  // Bench-made link clock, running only inside frames
  task automatic send2(input logic [31:0] v, input int n, input int dn, input int de);
    int d0;
    int e0;
    d0 = n_done;
    e0 = n_err;
    @(posedge i_clock);
    #3;
    link2.sync_n = 1'b0;
    for (int b = n - 1; b >= 0; b--) begin
      link2.sdin = v[b];
      #62.5;
      link2.sclk = 1'b0;
      #62.5;
      link2.sclk = 1'b1;
    end
    #62.5;
    link2.sync_n = 1'b1;
    link2.sdin = ~link2.sdin;
    repeat (30) @(posedge i_clock);
    chk(32'(n_done - d0), 32'(dn));
    chk(32'(n_err - e0), 32'(de));
    cmp2();
  endtask
  initial begin
    #800000;
    failures++;
    $display("watchdog expired");
    results();
  end
  initial begin
    logic [2:0] r;
    logic [1:0] c;
    logic [15:0] d;
    logic [15:0] code;
    logic [12:0] bst;
    logic [2:0] rng;
    link2.sclk = 1'b1;
    link2.sync_n = 1'b1;
    link2.sdin = 1'b0;
    link2.dev_reset = 1'b0;
    for (int k = 0; k < NUM_CH; k++) begin
      exp_code[k] = CODE_RESET;
      exp_gain[k] = GAIN_RESET;
      exp_off[k] = OFFSET_RESET;
    end
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    cmp2();
    chk(32'(drive2), 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 15; i++) begin
      r = regs[i % 5];
      c = 2'($random(seed));
      d = 16'($random(seed));
      model(r, c, d);
      send2({8'h00, 1'b0, strap2, r, c, d}, 24, 1, 0);
      chk(32'(busy2[c] | (r != REG_CODE)), 32'h1);
    end
    $display("test register decode done");
    strap2 <= 2'($random(seed));
    repeat (4) @(posedge i_clock);
    send2({8'h00, 1'b0, ~strap2, REG_CODE, 2'h0, 16'h1234}, 24, 0, 0);
    send2({8'h00, 1'b1, strap2, REG_CODE, 2'h0, 16'h1234}, 24, 0, 0);
    send2({9'h000, strap2, REG_CODE, 2'h0, 16'h1234} >> 1, 23, 0, 1);
    send2({7'h00, 1'b0, strap2, REG_CODE, 2'h0, 16'h1234, 1'b1}, 25, 0, 1);
    chk2 <= 1'b1;
    repeat (4) @(posedge i_clock);
    d = 16'($random(seed));
    model(REG_GAIN, 2'h3, d);
    send2({1'b0, strap2, REG_GAIN, 2'h3, d, 8'h5a}, 32, 1, 0);
    send2({9'h000, strap2, REG_GAIN, 2'h3, 16'h0}, 24, 0, 1);
    $display("test discard and length done");
    @(posedge i_clock);
    link2.dev_reset <= 1'b1;
    repeat (4) @(posedge i_clock);
    link2.dev_reset <= 1'b0;
    repeat (8) @(posedge i_clock);
    model(REG_GAIN_ALL, 2'h0, GAIN_RESET);
    model(REG_OFFSET_ALL, 2'h0, OFFSET_RESET);
    for (int k = 0; k < NUM_CH; k++) begin
      model(REG_CODE, 2'(k), CODE_RESET);
    end
    cmp2();
    $display("test hardware reset done");
    rng = 3'($random(seed));
    bst = 13'($random(seed));
    code = 16'($random(seed));
    apb(1'b1, ADDR_CONFIG, 32'(rng) << CFG_RANGE_LSB | 32'(strap1) << CFG_DEV_LSB);
    apb(1'b1, ADDR_BOOST, 32'(bst));
    apb(1'b1, ADDR_CODE, 32'(code));
    apb(1'b1, ADDR_COMMAND, 32'h1);
    wait_idle();
    chk(32'(bcfg1), 32'(bst));
    chk(32'({range1[0], int1[0], boost1[0]}), {27'h0, rng, 2'h3});
    chk(32'(code1[0]), 32'(code));
    chk(32'(drive1[0]), 32'h1);
    apb(1'b0, ADDR_CODE, 32'h0);
    chk(rd, 32'(code));
    apb(1'b0, 12'h018, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("test bring-up done");
    chk1 <= 1'b1;
    rng = rng + 3'h1;
    code = 16'($random(seed));
    apb(1'b1, ADDR_CONFIG, 32'(rng) << CFG_RANGE_LSB | 32'(strap1) << CFG_DEV_LSB |
      32'h1 << CFG_CHECK_BIT | 32'h1 << CFG_SKIP_RESET_BIT | 32'h1 << CFG_ZERO_FIRST_BIT |
      32'h1 << CFG_ZERO_MID_BIT);
    apb(1'b1, ADDR_CODE, 32'(code));
    apb(1'b1, ADDR_COMMAND, 32'h1);
    wait_idle();
    chk(32'(bcfg1), 32'(bst));
    chk(32'({range1[0], drive1[0]}), {28'h0, rng, 1'b1});
    chk(32'(code1[0]), 32'(code));
    chk1 <= 1'b0;
    d = 16'($random(seed));
    apb(1'b1, ADDR_CONFIG, 32'(strap1) << CFG_DEV_LSB);
    apb(1'b1, ADDR_RAW, {8'h00, 1'b0, strap1, REG_GAIN, 2'h1, d});
    apb(1'b1, ADDR_COMMAND, 32'h2);
    wait_idle();
    chk(32'(gain1[1]), 32'(d));
    $display("test range change and raw frame done");
    results();
  end
endmodule // tb_dac_frame_decode_and_bringup
`default_nettype wire
